/* rtl/l1m_consts.svh */
// l1m_consts.svh: offsets, field positions, reset values and sizes of l1m_ctrl
// assumes inclusion by bare name from rtl/
`ifndef L1M_CONSTS_SVH
`define L1M_CONSTS_SVH

`define L1M_NBANK      4
`define L1M_NCOL       8
`define L1M_ROWS       256
`define L1M_NREQ       4
`define L1M_ICC_N      4
`define L1M_RQ_DM      0
`define L1M_RQ_PM      1
`define L1M_RQ_FETCH   2
`define L1M_RQ_EXT     3

`define L1M_BYTE_TOP   16'h2000
`define L1M_SW_BASE    16'h4000
`define L1M_NW_BASE    16'h8000
`define L1M_ALIAS_LIM  16'h1000
`define L1M_CACHE_ROW0 8'he0
`define L1M_IVT_BASE   16'h0000

`define L1M_OFS_CTRL   4'h0
`define L1M_OFS_STAT   4'h4
`define L1M_OFS_CONF   4'h8
`define L1M_CTRL_B0PW  0
`define L1M_CTRL_B3PW  1
`define L1M_CTRL_CEN   2
`define L1M_CTRL_RST   3'h0
`define L1M_STAT_RST   4'h0

`endif

/* rtl/l1m_pkg.sv */
// l1m_pkg.sv: types of the level-one ram controller
// assumes nothing beyond the package itself
package l1m_pkg;

  typedef enum logic [2:0] {SZ_BYTE, SZ_SHORT, SZ_WORD, SZ_W48, SZ_LONG} l1m_size_e;
  typedef enum logic [1:0] {SP_BYTE, SP_SHORT, SP_NORMAL} l1m_space_e;

  typedef struct packed {
    logic        valid;
    logic        wr;
    l1m_space_e  space;
    l1m_size_e   size;
    logic        pair;
    logic        sext;
    logic [15:0] addr;
    logic [63:0] wdata;
  } l1m_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic        perr;
    logic [63:0] rdata;
  } l1m_rsp_s;

  typedef struct packed {
    logic       err;
    logic [1:0] bank;
    logic [7:0] row;
    logic [2:0] lane;
    logic [7:0] mask;
    logic [3:0] len;
    logic [3:0] offy;
    logic       pair;
    logic       skip;
  } l1m_dec_s;

endpackage

/* rtl/l1m_ctrl.sv */
// l1m_ctrl.sv: level-one ram controller, four banks of byte-wide columns
// assumes all requesters and the register port run on mclk and each
// requester holds its request until it sees ack
`include "l1m_consts.svh"

module l1m_ctrl (
  // clock, reset, enable
  input  logic                 mclk,
  input  logic                 srst,
  input  logic                 ce,
  // requesters: dm, pm, fetch, ext
  input  l1m_pkg::l1m_req_s    req [`L1M_NREQ],
  output l1m_pkg::l1m_rsp_s    rsp [`L1M_NREQ],
  // register port
  input  logic [3:0]           mmr_addr,
  input  logic [31:0]          mmr_wdata,
  input  logic                 mmr_wr,
  input  logic                 mmr_rd,
  output logic [31:0]          mmr_rdata,
  // interrupt vector
  input  logic                 int_latch,
  input  logic [5:0]           int_index,
  output logic [15:0]          vec_addr,
  output logic                 vec_valid
);
  import l1m_pkg::*;

  function automatic logic [1:0] first_f(input logic [3:0] v);
    return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [63:0] lmask_f(input logic [3:0] len);
    return 64'hffff_ffff_ffff_ffff >> (7'h40 - {len, 3'h0});
  endfunction

  function automatic l1m_dec_s dec_f(input l1m_req_s r, input logic [1:0] pw,
                                     input logic cen, input logic fet);
    l1m_dec_s   d;
    logic [15:0] rel;
    logic [15:0] ba;
    logic        pk;
    logic [7:0]  mx;
    d = '0;
    rel = 16'h0;
    ba = r.addr;
    case (r.space)
      SP_SHORT: begin
        rel = r.addr - `L1M_SW_BASE;
        ba = {rel[14:0], 1'b0};
        d.err = (r.addr < `L1M_SW_BASE) | (rel >= `L1M_ALIAS_LIM);
      end
      SP_NORMAL: begin
        rel = r.addr - `L1M_NW_BASE;
        ba = {rel[13:0], 2'h0};
        d.err = (r.addr < `L1M_NW_BASE) | (rel >= `L1M_ALIAS_LIM);
      end
      default: begin
        d.err = r.addr >= `L1M_BYTE_TOP;
      end
    endcase
    d.bank = ba[12:11];
    pk = ((d.bank == 2'h0) & pw[0]) | ((d.bank == 2'h3) & pw[1]);
    d.pair = r.pair & ~pk;
    case (r.size)
      SZ_BYTE: begin
        d.len = 4'h1;
        d.offy = 4'h1;
      end
      SZ_SHORT: begin
        d.len = 4'h2;
        d.offy = (r.space == SP_SHORT) ? 4'h4 : 4'h2;
      end
      SZ_WORD: begin
        if (pk) begin
          d.len = 4'h6;
          d.skip = 1'b1;
        end else begin
          d.len = 4'h4;
          d.offy = 4'h4;
          if (d.pair) begin
            ba[1:0] = 2'h0;
          end
        end
      end
      SZ_W48: begin
        d.len = 4'h6;
        d.pair = 1'b0;
      end
      default: begin
        d.len = 4'h8;
        d.pair = 1'b0;
        ba[2:0] = 3'h0;
      end
    endcase
    d.row = ba[10:3];
    d.lane = ba[2:0];
    mx = 8'hff >> (4'h8 - d.len);
    d.mask = mx | (d.pair ? 8'(mx << d.offy) : 8'h00);
    d.err = d.err | (fet & r.wr) | (cen & (d.row >= `L1M_CACHE_ROW0));
    return d;
  endfunction

  function automatic logic [63:0] wbuf_f(input logic [63:0] wd, input l1m_dec_s d,
                                         input logic [63:0] lm);
    if (d.skip) begin
      return {16'h0, wd[39:0], 8'h00};
    end
    if (d.pair) begin
      return (wd & lm) | (({32'h0, wd[63:32]} & lm) << {d.offy, 3'h0});
    end
    return wd;
  endfunction

  function automatic logic [31:0] ext_f(input logic [31:0] v, input l1m_req_s r);
    if (r.sext && r.size == SZ_BYTE) begin
      return {{24{v[7]}}, v[7:0]};
    end
    if (r.sext && r.size == SZ_SHORT) begin
      return {{16{v[15]}}, v[15:0]};
    end
    return v;
  endfunction

  function automatic logic [63:0] rdata_f(input logic [63:0] raw, input l1m_dec_s d,
                                          input l1m_req_s r, input logic [63:0] lm);
    logic [63:0] x;
    logic [63:0] y;
    x = raw & lm;
    y = (raw >> {d.offy, 3'h0}) & lm;
    if (d.skip) begin
      return {24'h0, raw[47:8]};
    end
    if (r.size == SZ_LONG || r.size == SZ_W48) begin
      return x;
    end
    return {d.pair ? ext_f(y[31:0], r) : 32'h0, ext_f(x[31:0], r)};
  endfunction

  // registers
  logic [2:0]   ctrl_q;
  logic [3:0]   pstk_q;
  logic [15:0]  conf_q;
  logic [31:0]  mmr_rdata_q;
  logic [15:0]  vec_addr_q;
  logic         vec_valid_q;
  l1m_rsp_s     rsp_q [`L1M_NREQ];

  // conflict cache
  logic [`L1M_ICC_N-1:0] iv_q;
  logic [15:0]           itag_q [`L1M_ICC_N];
  logic [63:0]           idat_q [`L1M_ICC_N];
  logic [1:0]            iptr_q;
  logic [`L1M_ICC_N-1:0] ih;
  logic [63:0]           idat_w;
  logic                  icc_use;

  // request decode and arbitration
  l1m_dec_s              dv [`L1M_NREQ];
  logic [`L1M_NREQ-1:0]  want;
  logic [`L1M_NREQ-1:0]  act;
  logic [`L1M_NREQ-1:0]  ub;
  logic [`L1M_NREQ-1:0]  gnt;
  logic [`L1M_NREQ-1:0]  done;
  logic [`L1M_NREQ-1:0]  wrv;
  logic [`L1M_NREQ-1:0]  perr_w;
  logic [`L1M_NREQ-1:0]  sb [`L1M_NREQ];
  logic [`L1M_NCOL-1:0]  cact [`L1M_NREQ];
  logic [7:0]            crow [`L1M_NREQ][`L1M_NCOL];
  logic [8:0]            cwd [`L1M_NREQ][`L1M_NCOL];
  logic [8:0]            rb [`L1M_NREQ][`L1M_NCOL];
  logic [8:0]            cdat [`L1M_NBANK][`L1M_NCOL];
  logic [63:0]           rdx [`L1M_NREQ];
  logic [`L1M_NBANK-1:0] pset;
  logic [1:0]            pw_w;
  logic                  wr_any;
  logic                  stall_any;

  assign pw_w = {ctrl_q[`L1M_CTRL_B3PW], ctrl_q[`L1M_CTRL_B0PW]};

  for (genvar i = 0; i < `L1M_NREQ; i++) begin : g_rq
    localparam logic [3:0] LO = 4'((1 << i) - 1);
    logic [63:0]          lm;
    logic [63:0]          wb;
    logic [63:0]          rw;
    logic [`L1M_NCOL-1:0] pe;
    assign dv[i] = dec_f(req[i], pw_w, ctrl_q[`L1M_CTRL_CEN], i == `L1M_RQ_FETCH);
    assign wrv[i] = req[i].wr;
    assign want[i] = req[i].valid & ~rsp_q[i].ack;
    assign act[i] = want[i] & ~dv[i].err;
    assign ub[i] = act[i] & ~((i == `L1M_RQ_FETCH) & icc_use);
    for (genvar j = 0; j < `L1M_NREQ; j++) begin : g_sb
      assign sb[i][j] = dv[j].bank == dv[i].bank;
    end
    assign gnt[i] = ub[i] & ~|(ub & sb[i] & LO);
    assign done[i] = gnt[i] | (want[i] & dv[i].err) | ((i == `L1M_RQ_FETCH) & icc_use);
    assign lm = lmask_f(dv[i].len);
    assign wb = wbuf_f(req[i].wdata, dv[i], lm);
    for (genvar k = 0; k < `L1M_NCOL; k++) begin : g_col
      logic [2:0] ri;
      assign ri = 3'(k) - dv[i].lane;
      assign cact[i][k] = dv[i].mask[ri];
      assign crow[i][k] = dv[i].row + 8'(3'(k) < dv[i].lane);
      assign cwd[i][k] = {^wb[{ri, 3'h0} +: 8], wb[{ri, 3'h0} +: 8]};
      assign rb[i][k] = cdat[dv[i].bank][3'(k) + dv[i].lane];
      assign rw[k*8 +: 8] = rb[i][k][7:0];
      assign pe[k] = dv[i].mask[k] & ^rb[i][k];
    end
    assign perr_w[i] = |pe;
    assign rdx[i] = rdata_f(rw, dv[i], req[i], lm);
  end

  // storage: per bank, per byte column, data plus parity
  for (genvar b = 0; b < `L1M_NBANK; b++) begin : g_bank
    logic [`L1M_NREQ-1:0] gbv;
    logic [1:0]           wi;
    for (genvar i = 0; i < `L1M_NREQ; i++) begin : g_gb
      assign gbv[i] = gnt[i] & (dv[i].bank == 2'(b));
    end
    assign wi = first_f(gbv);
    assign pset[b] = |(gbv & ~wrv & perr_w);
    for (genvar c = 0; c < `L1M_NCOL; c++) begin : g_col
      logic [8:0] mem [`L1M_ROWS];
      logic [7:0] row;
      logic       we;
      assign row = crow[wi][c];
      assign we = |gbv & cact[wi][c] & wrv[wi];
      always_ff @(posedge mclk) begin
        if (ce && we) begin
          mem[row] <= cwd[wi][c];
        end
      end
      assign cdat[b][c] = mem[row];
    end
  end

  // conflict cache lookup
  for (genvar e = 0; e < `L1M_ICC_N; e++) begin : g_icc
    assign ih[e] = iv_q[e] & (itag_q[e] == req[`L1M_RQ_FETCH].addr);
  end
  assign idat_w = idat_q[first_f(ih)];
  assign icc_use = act[`L1M_RQ_FETCH] & act[`L1M_RQ_PM]
                 & sb[`L1M_RQ_FETCH][`L1M_RQ_PM] & |ih;
  assign wr_any = |(gnt & wrv);
  assign stall_any = |(ub & ~gnt);

  always_ff @(posedge mclk) begin
    if (srst) begin
      iv_q <= '0;
      iptr_q <= 2'h0;
    end else if (ce) begin
      if (wr_any) begin
        iv_q <= '0;
      end
      if (gnt[`L1M_RQ_FETCH]) begin
        iv_q[iptr_q] <= 1'b1;
        itag_q[iptr_q] <= req[`L1M_RQ_FETCH].addr;
        idat_q[iptr_q] <= rdx[`L1M_RQ_FETCH];
        iptr_q <= iptr_q + 2'h1;
      end
    end
  end

  // responses, one cycle after the request is taken
  for (genvar i = 0; i < `L1M_NREQ; i++) begin : g_rsp
    logic from_icc;
    logic rd_ok;
    assign from_icc = (i == `L1M_RQ_FETCH) & icc_use;
    assign rd_ok = gnt[i] & ~wrv[i];
    always_ff @(posedge mclk) begin
      if (srst) begin
        rsp_q[i] <= '0;
      end else if (ce) begin
        rsp_q[i].ack <= done[i];
        rsp_q[i].err <= want[i] & dv[i].err;
        rsp_q[i].perr <= rd_ok & perr_w[i];
        rsp_q[i].rdata <= from_icc ? idat_w : (rd_ok ? rdx[i] : 64'h0);
      end
    end
    assign rsp[i] = rsp_q[i];
  end

  // register port, separate from the memory path
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_conf;
  logic [31:0] rd_mux;
  assign sel_ctrl = mmr_addr == `L1M_OFS_CTRL;
  assign sel_stat = mmr_addr == `L1M_OFS_STAT;
  assign sel_conf = mmr_addr == `L1M_OFS_CONF;
  assign rd_mux = sel_ctrl ? {29'h0, ctrl_q} :
                  sel_stat ? {28'h0, pstk_q} :
                  sel_conf ? {16'h0, conf_q} : 32'h0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= `L1M_CTRL_RST;
      pstk_q <= `L1M_STAT_RST;
      conf_q <= 16'h0;
      mmr_rdata_q <= 32'h0;
    end else if (ce) begin
      if (mmr_wr && sel_ctrl) begin
        ctrl_q <= mmr_wdata[2:0];
      end
      // write-one-to-clear; a new error in the same cycle stays set
      pstk_q <= (pstk_q & ~((mmr_wr && sel_stat) ? mmr_wdata[3:0] : 4'h0)) | pset;
      conf_q <= conf_q + 16'(stall_any);
      mmr_rdata_q <= mmr_rd ? rd_mux : 32'h0;
    end
  end
  assign mmr_rdata = mmr_rdata_q;

  // vector table entry for a latched interrupt
  always_ff @(posedge mclk) begin
    if (srst) begin
      vec_addr_q <= `L1M_IVT_BASE;
      vec_valid_q <= 1'b0;
    end else if (ce) begin
      vec_valid_q <= int_latch;
      if (int_latch) begin
        vec_addr_q <= `L1M_IVT_BASE + {8'h0, int_index, 2'h0};
      end
    end
  end
  assign vec_addr = vec_addr_q;
  assign vec_valid = vec_valid_q;

endmodule

/* dv/l1m_req_model.sv */
// l1m_req_model.sv: one requester (core bus or dma) of l1m_ctrl
// assumes mclk shared with l1m_ctrl; called at a rising edge
module l1m_req_model import l1m_pkg::*; (
  // clock
  input  logic     mclk,
  // request and answer
  output l1m_req_s req,
  input  l1m_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // hold the request unchanged until ack is sampled or 50 cycles have passed
  task automatic go(input l1m_req_s r, output l1m_rsp_s a);
    int n;
    n = 0;
    r.valid = 1'b1;
    req <= r;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    a = rsp;
    r = ~r;
    r.valid = 1'b0;
    req <= r;
    @(posedge mclk);
  endtask
endmodule

/* dv/l1m_ctrl_sva.sv */
// l1m_ctrl_sva.sv: port assertions for l1m_ctrl
// assumes one clock mclk, srst synchronous active high
`include "l1m_consts.svh"

module l1m_ctrl_sva (
  // clock, reset, enable
  input logic              mclk,
  input logic              srst,
  input logic              ce,
  // requesters
  input l1m_pkg::l1m_req_s req [`L1M_NREQ],
  input l1m_pkg::l1m_rsp_s rsp [`L1M_NREQ],
  // register port and vector
  input logic [3:0]        mmr_addr,
  input logic [31:0]       mmr_wdata,
  input logic              mmr_wr,
  input logic              mmr_rd,
  input logic [31:0]       mmr_rdata,
  input logic              int_latch,
  input logic [5:0]        int_index,
  input logic [15:0]       vec_addr,
  input logic              vec_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import l1m_pkg::*;
  // waiting requests, byte space, in range, outside cache rows
  wire r0_go = ce && req[0].valid && !rsp[0].ack;
  wire r0_ok = r0_go && req[0].space == SP_BYTE && req[0].addr[15:13] == 3'h0
               && req[0].addr[10:8] != 3'h7;
  wire r3_ok = ce && req[3].valid && !rsp[3].ack && req[3].space == SP_BYTE
               && req[3].addr[15:13] == 3'h0 && req[3].addr[10:8] != 3'h7;
  wire two   = r0_ok && r3_ok && !req[1].valid && !req[2].valid;
  wire same  = req[0].addr[12:11] == req[3].addr[12:11];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  r0_nostall_a: assert property (r0_go |=> rsp[0].ack)
    else $error("requester 0 not answered next cycle");
  ack_pulse_a: assert property (rsp[0].ack |=> !rsp[0].ack)
    else $error("ack longer than one cycle");
  bank_par_a: assert property (two && !same |=> rsp[0].ack && rsp[3].ack)
    else $error("ext stalled on another bank");
  bank_hold_a: assert property (two && same |=> rsp[0].ack && !rsp[3].ack ##1 rsp[3].ack)
    else $error("same bank order wrong");
  fetch_ro_a: assert property (ce && req[2].valid && req[2].wr && !rsp[2].ack
                               |=> rsp[2].ack && rsp[2].err)
    else $error("fetch write not refused");
  mmr_quiet_a: assert property (!mmr_rd |=> mmr_rdata == 32'h0)
    else $error("register data without read");
  vec_load_a: assert property (ce && int_latch |=> vec_valid
                               && vec_addr == {8'h00, $past(int_index), 2'h0})
    else $error("vector address wrong");
  vec_hold_a: assert property (!int_latch |=> $stable(vec_addr) && !vec_valid)
    else $error("vector changed without latch");
endmodule

bind l1m_ctrl l1m_ctrl_sva u_l1m_ctrl_sva (
  .mclk(mclk), .srst(srst), .ce(ce), .req(req), .rsp(rsp),
  .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
  .mmr_rdata(mmr_rdata), .int_latch(int_latch), .int_index(int_index),
  .vec_addr(vec_addr), .vec_valid(vec_valid));

/* dv/l1_memory_byte_space_access_tb_top.sv */
// l1_memory_byte_space_access_tb_top.sv: self-checking bench of l1m_ctrl
// assumes l1m_req_model on every requester port, checker bound
`include "l1m_consts.svh"

module l1_memory_byte_space_access_tb_top import l1m_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  l1m_req_s    req [`L1M_NREQ];
  l1m_rsp_s    rsp [`L1M_NREQ];
  logic [3:0]  mmr_addr = 4'h0;
  logic [31:0] mmr_wdata = 32'h0;
  logic [31:0] mmr_rdata;
  logic        mmr_wr = 1'b0;
  logic        mmr_rd = 1'b0;
  logic        int_latch = 1'b0;
  logic [5:0]  int_index = 6'h0;
  logic [15:0] vec_addr;
  logic        vec_valid;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;

  always #4 mclk = ~mclk;

  l1m_ctrl u_l1m_ctrl (
    .mclk(mclk), .srst(srst), .ce(ce), .req(req), .rsp(rsp), .mmr_addr(mmr_addr),
    .mmr_wdata(mmr_wdata), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata),
    .int_latch(int_latch), .int_index(int_index), .vec_addr(vec_addr),
    .vec_valid(vec_valid));

  for (genvar i = 0; i < `L1M_NREQ; i++) begin : g_rq
    l1m_req_model u_l1m_req_model (.mclk(mclk), .req(req[i]), .rsp(rsp[i]));
  end

  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic l1m_req_s mk(input l1m_size_e sz, input logic [15:0] a,
    input logic pr = 1'b0, input logic sx = 1'b0, input logic w = 1'b0,
    input logic [63:0] d = '0, input l1m_space_e sp = SP_BYTE);
    return '{1'b1, w, sp, sz, pr, sx, a, d};
  endfunction

  task automatic acc(input int k, input l1m_req_s r, output l1m_rsp_s a);
    case (k)
      0: g_rq[0].u_l1m_req_model.go(r, a);
      1: g_rq[1].u_l1m_req_model.go(r, a);
      2: g_rq[2].u_l1m_req_model.go(r, a);
      default: g_rq[3].u_l1m_req_model.go(r, a);
    endcase
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    mmr_wr <= 1'b1;
    mmr_addr <= a;
    mmr_wdata <= d;
    @(posedge mclk);
    mmr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    mmr_rd <= 1'b1;
    mmr_addr <= a;
    @(posedge mclk);
    mmr_rd <= 1'b0;
    @(posedge mclk);
    d = mmr_rdata;
  endtask

  // one long write, then byte, short, word and 48-bit reads, with and without pairing
  task automatic s_bytes();
    l1m_req_s q [7];
    logic [63:0] e [7];
    l1m_rsp_s a;
    q = '{mk(SZ_BYTE, 16'h0012, 1'b0, 1'b1), mk(SZ_BYTE, 16'h0012),
          mk(SZ_BYTE, 16'h0013, 1'b1), mk(SZ_SHORT, 16'h0013, 1'b1),
          mk(SZ_WORD, 16'h0010, 1'b1), mk(SZ_W48, 16'h0011),
          mk(SZ_SHORT, 16'h4008, 1'b0, 1'b0, 1'b0, '0, SP_SHORT)};
    e = '{64'hffff_fff3, 64'hf3, 64'h55_0000_0044, 64'h7766_0000_5544,
          64'h8877_6655_44f3_2211, 64'h7766_5544_f322, 64'h2211};
    acc(0, mk(SZ_LONG, 16'h0010, 1'b0, 1'b0, 1'b1, 64'h8877_6655_44f3_2211), a);
    chk("write err", a.err, 1'b0);
    for (int i = 0; i < 7; i++) begin
      acc((i % 2) * 3, q[i], a);
      chk("read data", a.rdata, e[i]);
      chk("parity err", a.perr, 1'b0);
    end
  endtask

  task automatic s_conflict();
    l1m_rsp_s a;
    l1m_rsp_s b;
    logic [31:0] d;
    fork
      acc(0, mk(SZ_WORD, 16'h0010), a);
      acc(3, mk(SZ_WORD, 16'h0014), b);
    join
    chk("first data", a.rdata, 64'h44f3_2211);
    chk("stalled data", b.rdata, 64'h8877_6655);
    fork
      acc(0, mk(SZ_WORD, 16'h0010), a);
      acc(3, mk(SZ_BYTE, 16'h0810, 1'b0, 1'b0, 1'b1, 64'h5a), b);
    join
    chk("other bank err", b.err, 1'b0);
    rd(4'h8, d);
    chk("conflict count", d, 32'h1);
  endtask

  task automatic s_err();
    l1m_rsp_s a;
    logic [31:0] d;
    acc(2, mk(SZ_WORD, 16'h0010, 1'b0, 1'b0, 1'b1), a);
    chk("fetch write", a.err, 1'b1);
    acc(1, mk(SZ_BYTE, 16'h2000), a);
    chk("out of range", a.err, 1'b1);
    wr(4'h0, 32'h4);
    rd(4'h0, d);
    chk("control", d, 32'h4);
    acc(1, mk(SZ_BYTE, 16'h0700), a);
    chk("cache row", a.err, 1'b1);
    acc(1, mk(SZ_BYTE, 16'h06ff), a);
    chk("below cache", a.err, 1'b0);
    rd(4'hc, d);
    chk("unmapped", d, 32'h0);
    wr(4'h0, 32'h0);
  endtask

  // conflict cache serves a fetch beside pm data, then packed bank 0
  task automatic s_icc();
    l1m_rsp_s a;
    l1m_rsp_s b;
    logic [31:0] d;
    acc(2, mk(SZ_WORD, 16'h0010), a);
    chk("fetch fill", a.rdata, 64'h44f3_2211);
    fork
      acc(1, mk(SZ_WORD, 16'h0014), b);
      acc(2, mk(SZ_WORD, 16'h0010), a);
    join
    chk("cache fetch", a.rdata, 64'h44f3_2211);
    chk("pm data", b.rdata, 64'h8877_6655);
    rd(4'h8, d);
    chk("no stall", d, 32'h1);
    wr(4'h0, 32'h1);
    acc(0, mk(SZ_WORD, 16'h0020, 1'b0, 1'b0, 1'b1, 64'h12_3456_789a), a);
    acc(3, mk(SZ_WORD, 16'h0020), a);
    chk("packed word", a.rdata, 64'h12_3456_789a);
    wr(4'h0, 32'h0);
    rd(4'h4, d);
    chk("parity sticky", d, 32'h0);
  endtask

  task automatic s_vec();
    int_latch <= 1'b1;
    int_index <= 6'h3f;
    @(posedge mclk);
    int_latch <= 1'b0;
    @(posedge mclk);
    chk("vector valid", vec_valid, 1'b1);
    chk("vector addr", vec_addr, 16'h00fc);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    s_bytes();
    s_conflict();
    s_err();
    s_icc();
    s_vec();
    stop_test();
  end
endmodule
